/* File: rtl/smbir_pkg.sv */
package smbir_pkg;

  // Register indices
  localparam logic [7:0] SMBIR_IDX_MODE = 8'h00;
  localparam logic [7:0] SMBIR_IDX_OE = 8'h01;
  localparam logic [7:0] SMBIR_IDX_STOP = 8'h02;
  localparam logic [7:0] SMBIR_IDX_RSVD = 8'h03;
  localparam logic [7:0] SMBIR_IDX_IDENT = 8'h04;
  localparam logic [7:0] SMBIR_IDX_COUNT = 8'h06;

  // Field positions in mode_and_divide_control
  localparam int SMBIR_PD_DRIVE_BIT = 7;
  localparam int SMBIR_STOP_DRIVE_BIT = 6;
  localparam int SMBIR_OP_HI_BIT = 3;
  localparam int SMBIR_OP_LO_BIT = 1;
  localparam int SMBIR_HALVE_BIT = 0;

  // Writable masks and values after reset
  localparam logic [7:0] SMBIR_MODE_MASK = 8'hCB;
  localparam logic [7:0] SMBIR_MODE_RST = 8'h81;
  localparam logic [7:0] SMBIR_OE_MASK = 8'h66;
  localparam logic [7:0] SMBIR_OE_RST = 8'hE6;
  localparam logic [7:0] SMBIR_STOP_MASK = 8'h66;
  localparam logic [7:0] SMBIR_STOP_RST = 8'h00;
  localparam logic [7:0] SMBIR_COUNT_RST = 8'h07;

  // Target address with the select pin at its middle level
  localparam logic [7:0] SMBIR_ADDR_MID = 8'hDC;

  // Address select pin codes
  localparam logic [1:0] SMBIR_SEL_LOW = 2'h0;
  localparam logic [1:0] SMBIR_SEL_MID = 2'h1;

  // Synchroniser width and strap settle count
  localparam int SMBIR_SYNC_W = 11;
  localparam logic [2:0] SMBIR_SETTLE_CYCLES = 3'h5;

  typedef enum logic [2:0] {
    SMBIR_IDLE = 3'b000,
    SMBIR_ADDR = 3'b001,
    SMBIR_INDEX = 3'b010,
    SMBIR_COUNT = 3'b011,
    SMBIR_WDATA = 3'b100,
    SMBIR_ACK = 3'b101,
    SMBIR_RDATA = 3'b110,
    SMBIR_HACK = 3'b111
  } smbir_state_e;

endpackage : smbir_pkg

/* File: rtl/smbir_top.sv */
// Function
// - Device acknowledges start index and count
// - Store X data bytes from N onward
// - Mid-level select answers DC write, DD read
// - Read: index, repeated start, read address acknowledged
// - Read returns byte count, then registers from N
// - Reg0 bit7 power-down drive mode, reset 1
// - Reg0 bit6 stopped-output drive mode, reset 0
// - Reg0 bits 3,1 mode, latched from strap
// - Reg0 bit0 divider select, reset 1
// - Reg1 output enables, reset 1
// - Output runs with enable, and needs pin only if stoppable
// - Reg2 stoppable select per output, reset 0
// - Reg4 read-only revision and vendor codes
// - Reg6 read byte count, reset 7
// - Power-down: true high or floated, complement floated
`timescale 1ns/1ps
`default_nettype none
module smbir_top #(
  parameter logic [7:0] ADDR_LOW = 8'hD8,
  parameter logic [7:0] ADDR_HIGH = 8'hDE,
  // Arbitrary identification values
  parameter logic [3:0] REV_CODE = 4'h2,
  parameter logic [3:0] VEN_CODE = 4'hA
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // SMBus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Device pins
  input wire logic [1:0] i_tri_level_addr_pin,
  input wire logic [1:0] i_mode_strap,
  input wire logic i_power_down_n,
  input wire logic [3:0] i_out_enable_n,
  // Output control
  output logic [3:0] o_out_run,
  output logic [3:0] o_out_stop_hiz,
  output logic o_pd_true_high,
  output logic o_pd_true_hiz,
  output logic o_pd_comp_hiz,
  output logic [1:0] o_op_mode,
  output logic o_ref_halve_select
);
  import smbir_pkg::*;

  logic [SMBIR_SYNC_W-1:0] sync_in;
  logic [SMBIR_SYNC_W-1:0] s1_reg;
  logic [SMBIR_SYNC_W-1:0] s2_reg;
  logic [SMBIR_SYNC_W-1:0] s3_reg;
  logic [SMBIR_SYNC_W-1:0] stable_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  smbir_state_e state_reg;
  smbir_state_e after_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_reg;
  logic got_reg;
  logic nak_reg;
  logic rd_first_reg;
  logic [7:0] index_reg;
  logic [7:0] wr_left_reg;
  logic [7:0] mode_reg;
  logic [7:0] oe_reg;
  logic [7:0] stop_reg;
  logic [7:0] count_reg;
  logic [2:0] settle_reg;
  logic strap_done_reg;
  logic sda_oe_reg;
  logic sda_o_reg;
  logic [3:0] run_reg;
  logic [3:0] stop_hiz_reg;
  logic pd_high_reg;
  logic pd_thiz_reg;
  logic pd_chiz_reg;

  assign sync_in = {i_tri_level_addr_pin, i_mode_strap, i_out_enable_n, i_power_down_n,
                    i_sda, i_scl};

  // Three-stage synchronisers, change taken when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < SMBIR_SYNC_W; g++)
    begin : g_sync
      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          s1_reg[g] <= 1'b1;
          s2_reg[g] <= 1'b1;
          s3_reg[g] <= 1'b1;
          stable_reg[g] <= 1'b1;
        end
        else if (i_ce)
        begin
          s1_reg[g] <= sync_in[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g])
            stable_reg[g] <= s3_reg[g];
        end
      end
    end
  endgenerate

  wire scl_s = stable_reg[0];
  wire sda_s = stable_reg[1];
  wire pd_s = ~stable_reg[2];
  wire [3:0] oe_n_s = stable_reg[6:3];
  wire [1:0] strap_s = stable_reg[8:7];
  wire [1:0] sel_s = stable_reg[10:9];

  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;
  wire bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire bus_stop = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // Own address by select pin level
  wire [7:0] own_addr = (sel_s == SMBIR_SEL_MID) ? SMBIR_ADDR_MID :
                        (sel_s == SMBIR_SEL_LOW) ? ADDR_LOW : ADDR_HIGH;
  wire addr_hit = (shift_reg[7:1] == own_addr[7:1]);

  // Readback of one register
  function automatic logic [7:0] rd_byte(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      SMBIR_IDX_MODE: v = mode_reg & SMBIR_MODE_MASK;
      SMBIR_IDX_OE: v = oe_reg;
      SMBIR_IDX_STOP: v = stop_reg & SMBIR_STOP_MASK;
      SMBIR_IDX_IDENT: v = {REV_CODE, VEN_CODE};
      SMBIR_IDX_COUNT: v = count_reg;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_byte

  wire [7:0] rd_next = rd_first_reg ? count_reg : rd_byte(index_reg);
  wire wr_now = (state_reg == SMBIR_WDATA) && scl_fall && got_reg && (wr_left_reg != 8'h00);

  // Edge history
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else if (i_ce)
    begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // Register file, writes through the bus and strap capture
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mode_reg <= SMBIR_MODE_RST;
      oe_reg <= SMBIR_OE_RST;
      stop_reg <= SMBIR_STOP_RST;
      count_reg <= SMBIR_COUNT_RST;
      settle_reg <= 3'h0;
      strap_done_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      if (!strap_done_reg)
      begin
        settle_reg <= settle_reg + 3'h1;
        if (settle_reg == SMBIR_SETTLE_CYCLES)
        begin
          strap_done_reg <= 1'b1;
          mode_reg[SMBIR_OP_HI_BIT] <= strap_s[1];
          mode_reg[SMBIR_OP_LO_BIT] <= strap_s[0];
        end
      end
      if (wr_now)
      begin
        unique case (index_reg)
          SMBIR_IDX_MODE: mode_reg <= (mode_reg & ~SMBIR_MODE_MASK) |
                                      (shift_reg & SMBIR_MODE_MASK);
          SMBIR_IDX_OE: oe_reg <= (oe_reg & ~SMBIR_OE_MASK) |
                                  (shift_reg & SMBIR_OE_MASK);
          SMBIR_IDX_STOP: stop_reg <= (stop_reg & ~SMBIR_STOP_MASK) |
                                      (shift_reg & SMBIR_STOP_MASK);
          SMBIR_IDX_COUNT: count_reg <= shift_reg;
          default: ;
        endcase
      end
    end
  end

  // Bus target state machine
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg <= SMBIR_IDLE;
      after_reg <= SMBIR_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 3'h0;
      got_reg <= 1'b0;
      nak_reg <= 1'b0;
      rd_first_reg <= 1'b0;
      index_reg <= 8'h00;
      wr_left_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      sda_o_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      sda_o_reg <= 1'b0;
      if (bus_start)
      begin
        state_reg <= SMBIR_ADDR;
        bit_reg <= 3'h0;
        got_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= SMBIR_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else
      begin
        unique case (state_reg)
          SMBIR_IDLE: ;
          SMBIR_ADDR, SMBIR_INDEX, SMBIR_COUNT, SMBIR_WDATA:
          begin
            if (scl_rise)
            begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_reg <= bit_reg + 3'h1;
              got_reg <= (bit_reg == 3'h7);
            end
            else if (scl_fall && got_reg)
            begin
              got_reg <= 1'b0;
              sda_oe_reg <= 1'b1;
              state_reg <= SMBIR_ACK;
              unique case (state_reg)
                SMBIR_ADDR:
                begin
                  rd_first_reg <= 1'b1;
                  after_reg <= shift_reg[0] ? SMBIR_RDATA : SMBIR_INDEX;
                  if (!addr_hit)
                  begin
                    sda_oe_reg <= 1'b0;
                    state_reg <= SMBIR_IDLE;
                  end
                end
                SMBIR_INDEX:
                begin
                  index_reg <= shift_reg;
                  after_reg <= SMBIR_COUNT;
                end
                SMBIR_COUNT:
                begin
                  wr_left_reg <= shift_reg;
                  after_reg <= SMBIR_WDATA;
                end
                default:
                begin
                  after_reg <= SMBIR_WDATA;
                  if (wr_left_reg != 8'h00)
                  begin
                    index_reg <= index_reg + 8'h01;
                    wr_left_reg <= wr_left_reg - 8'h01;
                  end
                end
              endcase
            end
          end
          SMBIR_ACK:
          begin
            if (scl_fall)
            begin
              state_reg <= after_reg;
              bit_reg <= 3'h0;
              if (after_reg == SMBIR_RDATA)
              begin
                shift_reg <= rd_next;
                sda_oe_reg <= ~rd_next[7];
                rd_first_reg <= 1'b0;
                if (!rd_first_reg)
                  index_reg <= index_reg + 8'h01;
              end
              else
                sda_oe_reg <= 1'b0;
            end
          end
          SMBIR_RDATA:
          begin
            if (scl_fall)
            begin
              if (bit_reg == 3'h7)
              begin
                sda_oe_reg <= 1'b0;
                state_reg <= SMBIR_HACK;
              end
              else
              begin
                sda_oe_reg <= ~shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 3'h1;
              end
            end
          end
          SMBIR_HACK:
          begin
            if (scl_rise)
              nak_reg <= sda_s;
            else if (scl_fall)
            begin
              bit_reg <= 3'h0;
              if (nak_reg)
                state_reg <= SMBIR_IDLE;
              else
              begin
                state_reg <= SMBIR_RDATA;
                shift_reg <= rd_next;
                sda_oe_reg <= ~rd_next[7];
                rd_first_reg <= 1'b0;
                if (!rd_first_reg)
                  index_reg <= index_reg + 8'h01;
              end
            end
          end
        endcase
      end
    end
  end

  // Output run and drive control
  generate
    for (g = 0; g < 4; g++)
    begin : g_out
      localparam int RB = (g < 2) ? g + 1 : g + 3;
      wire run_w = ~pd_s & oe_reg[RB] & (~stop_reg[RB] | ~oe_n_s[g]);
      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          run_reg[g] <= 1'b0;
          stop_hiz_reg[g] <= 1'b0;
        end
        else if (i_ce)
        begin
          run_reg[g] <= run_w;
          stop_hiz_reg[g] <= ~run_w & ~pd_s & mode_reg[SMBIR_STOP_DRIVE_BIT];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pd_high_reg <= 1'b0;
      pd_thiz_reg <= 1'b0;
      pd_chiz_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      pd_high_reg <= pd_s & ~mode_reg[SMBIR_PD_DRIVE_BIT];
      pd_thiz_reg <= pd_s & mode_reg[SMBIR_PD_DRIVE_BIT];
      pd_chiz_reg <= pd_s;
    end
  end

  assign o_sda_o = sda_o_reg;
  assign o_sda_oe = sda_oe_reg;
  assign o_out_run = run_reg;
  assign o_out_stop_hiz = stop_hiz_reg;
  assign o_pd_true_high = pd_high_reg;
  assign o_pd_true_hiz = pd_thiz_reg;
  assign o_pd_comp_hiz = pd_chiz_reg;
  assign o_op_mode = {mode_reg[SMBIR_OP_HI_BIT], mode_reg[SMBIR_OP_LO_BIT]};
  assign o_ref_halve_select = mode_reg[SMBIR_HALVE_BIT];

endmodule : smbir_top
`default_nettype wire

/* File: tb/smbir_host.sv */
`timescale 1ns/1ps
`default_nettype none
module smbir_host (
  // Clock and wire level
  input wire logic i_clk,
  input wire logic i_sda,
  // Host pins, 1 releases
  output logic o_scl,
  output logic o_sda
);
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : w
  // Start or repeated start
  task automatic start();
    w(3);
    o_sda = 1'b1;
    w(4);
    o_scl = 1'b1;
    w(4);
    o_sda = 1'b0;
    w(4);
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    w(3);
    o_sda = 1'b0;
    w(3);
    o_scl = 1'b1;
    w(4);
    o_sda = 1'b1;
    w(4);
  endtask : stop
  // Eight bits MSB first, then ninth bit a
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] r,
    output logic k);
    logic [8:0] v;
    logic [8:0] s;
    v = {d, a};
    for (int i = 8; i >= 0; i--)
    begin
      w(3);
      o_sda = v[i];
      w(3);
      o_scl = 1'b1;
      w(1);
      s[i] = i_sda;
      w(1);
      o_scl = 1'b0;
    end
    r = s[8:1];
    k = ~s[0];
  endtask : xbyte
endmodule : smbir_host
`default_nettype wire

/* File: tb/smbir_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module smbir_sva (
  // Clock, reset, pins
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic [1:0] i_tri_level_addr_pin,
  input wire logic [1:0] i_mode_strap,
  input wire logic i_power_down_n,
  input wire logic [3:0] i_out_enable_n,
  // Outputs
  input wire logic [3:0] o_out_run,
  input wire logic [3:0] o_out_stop_hiz,
  input wire logic o_pd_true_high,
  input wire logic o_pd_true_hiz,
  input wire logic o_pd_comp_hiz,
  input wire logic [1:0] o_op_mode,
  input wire logic o_ref_halve_select
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  sda_open_drain_a: assert property (o_sda_o == 1'b0)
    else $error("sda data not low");
  pd_stops_all_a: assert property (!i_power_down_n [*6] |-> o_out_run == 4'h0)
    else $error("output runs in power down");
  pd_awake_a: assert property (i_power_down_n [*6] |-> !o_pd_comp_hiz)
    else $error("power down state while awake");
  pd_float_a: assert property (!i_power_down_n [*6] |->
    o_pd_comp_hiz && (o_pd_true_high != o_pd_true_hiz))
    else $error("power down drive wrong");
  stop_not_run_a: assert property ((o_out_run & o_out_stop_hiz) == 4'h0)
    else $error("stopped output also runs");
  pd_no_stop_a: assert property (o_pd_comp_hiz |-> o_out_stop_hiz == 4'h0)
    else $error("stop float during power down");
  ack_hold_a: assert property ($rose(o_sda_oe) |=> o_sda_oe [*5])
    else $error("sda drive too short");
  drive_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("sda changed while scl high");
  drive_bound_a: assert property (o_sda_oe |-> ##[1:80] !o_sda_oe)
    else $error("sda held low too long");
endmodule : smbir_sva
bind smbir_top smbir_sva u_sva (.i_clk, .i_arst_n, .i_ce, .i_scl, .i_sda, .o_sda_o,
  .o_sda_oe, .i_tri_level_addr_pin, .i_mode_strap, .i_power_down_n, .i_out_enable_n,
  .o_out_run, .o_out_stop_hiz, .o_pd_true_high, .o_pd_true_hiz, .o_pd_comp_hiz,
  .o_op_mode, .o_ref_halve_select);
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import smbir_pkg::*;
  logic clk, arst_n, scl, hsda, sda_o, sda_oe, pd_n, pth, ptz, pcz, half, k, ce;
  logic [3:0] run_hold;
  logic [1:0] pin, strap, opm;
  logic [3:0] oe_n, run, shz;
  logic [7:0] rd, rv;
  logic [7:0] m [0:7];
  logic [7:0] adr [0:2];
  logic [31:0] rs;
  int err_count, check_count;
  wire logic sda;
  assign sda = hsda & ~(sda_oe & ~sda_o);
  // Arbitrary identification values
  smbir_top #(.REV_CODE(4'h5), .VEN_CODE(4'h3)) u_dut (.i_clk(clk), .i_arst_n(arst_n),
    .i_ce(ce), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_tri_level_addr_pin(pin), .i_mode_strap(strap), .i_power_down_n(pd_n),
    .i_out_enable_n(oe_n), .o_out_run(run), .o_out_stop_hiz(shz), .o_pd_true_high(pth),
    .o_pd_true_hiz(ptz), .o_pd_comp_hiz(pcz), .o_op_mode(opm), .o_ref_halve_select(half));
  smbir_host u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : rnd
  function automatic logic [7:0] wmask(input int j);
    case (j)
      0: return SMBIR_MODE_MASK;
      1: return SMBIR_OE_MASK;
      2: return SMBIR_STOP_MASK;
      6: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction : wmask
  function automatic logic [3:0] exp_run();
    logic [3:0] en;
    logic [3:0] st;
    en = {m[1][6], m[1][5], m[1][2], m[1][1]};
    st = {m[2][6], m[2][5], m[2][2], m[2][1]};
    return {4{pd_n}} & en & (~st | ~oe_n);
  endfunction : exp_run
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic send(input logic [7:0] d);
    u_host.xbyte(d, 1'b1, rd, k);
    chk({7'h00, k}, 8'h01);
  endtask : send
  task automatic wr(input logic [7:0] n, input logic [7:0] x);
    logic [7:0] d;
    int j;
    u_host.start();
    send(8'hDC);
    send(n);
    send(x);
    for (int i = 0; i <= x; i++)
    begin
      d = rnd();
      j = n + i;
      send(d);
      if (i < x && j < 8)
        m[j] = (m[j] & ~wmask(j)) | (d & wmask(j));
    end
    u_host.stop();
  endtask : wr
  task automatic rd_all(input logic [7:0] n);
    u_host.start();
    send(8'hDC);
    send(n);
    u_host.start();
    send(8'hDD);
    u_host.xbyte(8'hFF, 1'b0, rd, k);
    chk(rd, m[6]);
    for (int i = n; i < 8; i++)
    begin
      u_host.xbyte(8'hFF, i == 7, rd, k);
      chk(rd, m[i]);
    end
    u_host.stop();
  endtask : rd_all
  task automatic pins();
    rv = rnd();
    ce = 1'b0;
    run_hold = run;
    oe_n = rv[3:0];
    repeat (8) @(posedge clk);
    #1;
    chk({4'h0, run}, {4'h0, run_hold});
    ce = 1'b1;
    pd_n = rv[7] | rv[6];
    repeat (8) @(posedge clk);
    #1;
    chk({4'h0, run}, {4'h0, exp_run()});
    chk({4'h0, shz}, {4'h0, {4{pd_n & m[0][6]}} & ~exp_run()});
    chk({5'h00, pth, ptz, pcz}, {5'h00, ~pd_n & ~m[0][7], ~pd_n & m[0][7], ~pd_n});
    chk({5'h00, opm, half}, {5'h00, m[0][3], m[0][1], m[0][0]});
  endtask : pins
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Run needs about 15000 cycles
  initial
  begin
    #6_000_000;
    err_count++;
    give_verdict();
  end
  initial
  begin
    rs = 32'h0000_0033;
    err_count = 0;
    check_count = 0;
    arst_n = 1'b0;
    ce = 1'b1;
    pin = 2'h1;
    strap = 2'h2;
    pd_n = 1'b1;
    oe_n = 4'h0;
    adr = '{8'hD8, 8'hDC, 8'hDE};
    m = '{8'h89, 8'hE6, 8'h00, 8'h00, 8'h53, 8'h00, 8'h07, 8'h00};
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1'b1;
    pins();
    rd_all(8'h00);
    for (int p = 0; p < 3; p++)
      for (int a = 0; a < 3; a++)
      begin
        pin = p[1:0];
        u_host.start();
        u_host.xbyte(adr[a], 1'b1, rd, k);
        chk({7'h00, k}, {7'h00, p == a});
        u_host.stop();
      end
    pin = 2'h1;
    repeat (12)
    begin
      rv = rnd();
      wr(rv & 8'h07, {6'h00, rv[4:3]});
      pins();
      rd_all(rnd() & 8'h07);
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire
